//--- logic/pdl_map.svh
`ifndef PDL_MAP_SVH
`define PDL_MAP_SVH
// ==========================================================================
// Register offsets (byte addresses on the register bus).
`define PDL_CTRL_OFF 8'h00
`define PDL_REF_DIV_OFF 8'h04
`define PDL_N_DIV_OFF 8'h08
`define PDL_LOCK_THR_OFF 8'h0c
`define PDL_STATUS_OFF 8'h10
`define PDL_CH_BASE_OFF 8'h20
// ==========================================================================
// Field positions.
`define PDL_CTRL_DBL_BIT 0
`define PDL_CTRL_PRE_LSB 4
`define PDL_STATUS_LOCK_BIT 0
`define PDL_STATUS_CNT_LSB 16
// ==========================================================================
// Legal divide ranges.
`define PDL_REF_DIV_MIN 12'h001
`define PDL_REF_DIV_MAX 12'hfff
`define PDL_PRE_MIN 4'h2
`define PDL_PRE_MAX 4'h8
`define PDL_N_DIV_MIN 18'h00001
`define PDL_N_DIV_MAX 18'h3ffff
`define PDL_CH_DIV_MIN 11'h001
`define PDL_CH_DIV_MAX 11'h415
// ==========================================================================
// Reset values.
`define PDL_RST_REF_DIV 12'h001
`define PDL_RST_PRE 4'h2
`define PDL_RST_N_DIV 18'h00001
`define PDL_RST_LOCK_THR 16'h0400
`define PDL_RST_CH_DIV 11'h001
// ==========================================================================
// Timing: the lock window in picoseconds and the bus clock period.
`define PDL_LOCK_WINDOW_PS 3700
`define PDL_CLK_PERIOD_PS 4000
`endif

//--- logic/pdl_pkg.sv
`default_nettype none
package pdl_pkg;
  // Loop divider settings held together as one word of configuration.
  typedef struct packed {
    logic ref_doubler_enable;
    logic [3:0] prescale;
    logic [11:0] ref_div;
    logic [17:0] n_div;
    logic [15:0] lock_count_threshold;
  } pdl_cfg_t;
  // Pending-edge tracker used by the lock window comparison.
  typedef struct packed {
    logic pend;
    logic [2:0] age;
  } pdl_edge_t;
endpackage
`default_nettype wire

//--- logic/pdl_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdl_map.svh"
// Notes on behaviour
// - Reference path divides oscillator events by reference divide 1 to 4095; at divide 1 ref_pd_clk stays low.
// - Doubler off counts rising edges only; on counts both edges, doubling.
// - Feedback path first divides VCO clock by prescaler 2 to 8.
// - Then divides by N 1 to 262143; feedback rate is VCO/(P*N); with N at 1 fb_pd_clk stays low.
// - Each output channel divides VCO clock by its divide 1 to 1045.
// - Each detector cycle with edges inside 3.7 ns window adds one count while the count is below the threshold; code window is one 4 ns clock cycle.
// - Lock is indicated only once count reaches the programmed threshold.
// - An edge pair outside the window clears the count to zero at once.
// - Lock count threshold is a software-writable register.
module pdl_top
  import pdl_pkg::*;
#(
  parameter int NUM_CH = 4
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ref_osc_input,
  input wire logic vco_clk,
  output logic ref_pd_clk,
  output logic fb_pd_clk,
  output logic [NUM_CH-1:0] ch_clk,
  output logic pll_locked
);
  // ========================================================================
  // Constants and elaboration checks.
  localparam int WinRaw = `PDL_LOCK_WINDOW_PS / `PDL_CLK_PERIOD_PS;
  localparam int WinCyc = (WinRaw < 1) ? 1 : WinRaw;
  localparam logic [2:0] WinLast = 3'(WinCyc - 1);

  if (NUM_CH < 1 || NUM_CH > 56) begin : g_bad_ch
    $error("NUM_CH must lie between 1 and 56.");
  end
  if (WinCyc > 8) begin : g_bad_win
    $error("Lock window exceeds the age counter.");
  end

  // Clamp a divide setting into its legal range, 32 bits wide.
  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // ========================================================================
  // Register bus state.
  pdl_cfg_t cfg_q;
  logic [10:0] ch_div_q [NUM_CH];
  logic act_q;
  logic wr_q;
  logic [7:0] addr_q;
  logic [31:0] rd_d;
  logic [31:0] hrdata_q;
  logic [15:0] lock_cnt_q;
  logic [15:0] lock_cnt_d;
  logic locked_q;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Address phase capture; only NONSEQ or SEQ transfers are acted upon.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      act_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else if (hready)
    begin
      act_q <= hsel && htrans[1];
      wr_q <= hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // Read mux from the address phase; unmapped addresses read as zero.
  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (haddr[7:0])
      `PDL_CTRL_OFF:
      begin
        rd_d[`PDL_CTRL_DBL_BIT] = cfg_q.ref_doubler_enable;
        rd_d[`PDL_CTRL_PRE_LSB +: 4] = cfg_q.prescale;
      end
      `PDL_REF_DIV_OFF: rd_d[11:0] = cfg_q.ref_div;
      `PDL_N_DIV_OFF: rd_d[17:0] = cfg_q.n_div;
      `PDL_LOCK_THR_OFF: rd_d[15:0] = cfg_q.lock_count_threshold;
      `PDL_STATUS_OFF:
      begin
        rd_d[`PDL_STATUS_LOCK_BIT] = locked_q;
        rd_d[`PDL_STATUS_CNT_LSB +: 16] = lock_cnt_q;
      end
      default:
      begin
        for (int i = 0; i < NUM_CH; i++)
        begin
          if (haddr[7:0] == 8'(`PDL_CH_BASE_OFF + 4 * i))
          begin
            rd_d[10:0] = ch_div_q[i];
          end
        end
      end
    endcase
  end

  // Read data is registered so it stands through the data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_q <= 32'h0000_0000;
    end
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      hrdata_q <= rd_d;
    end
  end

  // Data phase writes; out-of-range divides are clamped on entry.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_q.ref_doubler_enable <= 1'b0;
      cfg_q.prescale <= `PDL_RST_PRE;
      cfg_q.ref_div <= `PDL_RST_REF_DIV;
      cfg_q.n_div <= `PDL_RST_N_DIV;
      cfg_q.lock_count_threshold <= `PDL_RST_LOCK_THR;
      for (int i = 0; i < NUM_CH; i++)
      begin
        ch_div_q[i] <= `PDL_RST_CH_DIV;
      end
    end
    else if (act_q && wr_q)
    begin
      case (addr_q)
        `PDL_CTRL_OFF:
        begin
          cfg_q.ref_doubler_enable <= hwdata[`PDL_CTRL_DBL_BIT];
          cfg_q.prescale <= 4'(clamp(32'(hwdata[`PDL_CTRL_PRE_LSB +: 4]),
                                     32'(`PDL_PRE_MIN),
                                     32'(`PDL_PRE_MAX)));
        end
        `PDL_REF_DIV_OFF:
          cfg_q.ref_div <= 12'(clamp(32'(hwdata[11:0]),
                                     32'(`PDL_REF_DIV_MIN),
                                     32'(`PDL_REF_DIV_MAX)));
        `PDL_N_DIV_OFF:
          cfg_q.n_div <= 18'(clamp(32'(hwdata[17:0]),
                                   32'(`PDL_N_DIV_MIN),
                                   32'(`PDL_N_DIV_MAX)));
        `PDL_LOCK_THR_OFF:
          cfg_q.lock_count_threshold <= hwdata[15:0];
        default:
        begin
          for (int i = 0; i < NUM_CH; i++)
          begin
            if (addr_q == 8'(`PDL_CH_BASE_OFF + 4 * i))
            begin
              ch_div_q[i] <= 11'(clamp(32'(hwdata[10:0]),
                                       32'(`PDL_CH_DIV_MIN),
                                       32'(`PDL_CH_DIV_MAX)));
            end
          end
        end
      endcase
    end
  end

  // ========================================================================
  // Pin synchronisers; the third stage only feeds edge detection.
  logic [2:0] osc_sync_q;
  logic [2:0] vco_sync_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      osc_sync_q <= 3'h0;
      vco_sync_q <= 3'h0;
    end
    else
    begin
      osc_sync_q <= {osc_sync_q[1:0], ref_osc_input};
      vco_sync_q <= {vco_sync_q[1:0], vco_clk};
    end
  end

  logic osc_rise;
  logic osc_fall;
  logic vco_rise;
  logic ref_ev;

  assign osc_rise = osc_sync_q[1] && !osc_sync_q[2];
  assign osc_fall = !osc_sync_q[1] && osc_sync_q[2];
  assign vco_rise = vco_sync_q[1] && !vco_sync_q[2];
  assign ref_ev = osc_rise || (cfg_q.ref_doubler_enable && osc_fall);

  // ========================================================================
  // Reference and feedback dividers; each emits one pulse per period.
  logic [11:0] ref_cnt_q;
  logic [3:0] pre_cnt_q;
  logic [17:0] n_cnt_q;
  logic ref_p;
  logic pre_p;
  logic fb_p;

  assign ref_p = ref_ev && (ref_cnt_q >= cfg_q.ref_div - 12'h001);
  assign pre_p = vco_rise && (pre_cnt_q >= cfg_q.prescale - 4'h1);
  assign fb_p = pre_p && (n_cnt_q >= cfg_q.n_div - 18'h00001);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ref_cnt_q <= 12'h000;
      pre_cnt_q <= 4'h0;
      n_cnt_q <= 18'h00000;
      ref_pd_clk <= 1'b0;
      fb_pd_clk <= 1'b0;
    end
    else
    begin
      if (ref_ev)
      begin
        ref_cnt_q <= ref_p ? 12'h000 : ref_cnt_q + 12'h001;
      end
      if (vco_rise)
      begin
        pre_cnt_q <= pre_p ? 4'h0 : pre_cnt_q + 4'h1;
      end
      if (pre_p)
      begin
        n_cnt_q <= fb_p ? 18'h00000 : n_cnt_q + 18'h00001;
      end
      ref_pd_clk <= ref_cnt_q < {1'b0, cfg_q.ref_div[11:1]};
      fb_pd_clk <= n_cnt_q < {1'b0, cfg_q.n_div[17:1]};
    end
  end

  // ========================================================================
  // Output channel dividers; divide by one passes the synced VCO level.
  logic [10:0] ch_cnt_q [NUM_CH];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        ch_cnt_q[i] <= 11'h000;
      end
      ch_clk <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (vco_rise)
        begin
          ch_cnt_q[i] <= (ch_cnt_q[i] >= ch_div_q[i] - 11'h001) ?
                         11'h000 : ch_cnt_q[i] + 11'h001;
        end
        ch_clk[i] <= (ch_div_q[i] == 11'h001) ? vco_sync_q[1] :
                     (ch_cnt_q[i] < {1'b0, ch_div_q[i][10:1]});
      end
    end
  end

  // ========================================================================
  // Lock window: an edge waits up to WinCyc cycles for its partner.
  pdl_edge_t ref_e_q;
  pdl_edge_t fb_e_q;
  logic in_win;
  logic out_win;

  assign in_win = (ref_p && (fb_p || fb_e_q.pend)) ||
                  (fb_p && ref_e_q.pend);
  assign out_win = (ref_e_q.pend && !fb_p &&
                    (ref_e_q.age >= WinLast || ref_p)) ||
                   (fb_e_q.pend && !ref_p &&
                    (fb_e_q.age >= WinLast || fb_p));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ref_e_q <= '0;
      fb_e_q <= '0;
    end
    else
    begin
      if (ref_p && !fb_p && !fb_e_q.pend)
        ref_e_q <= '{pend: 1'b1, age: 3'h0};
      else if (fb_p || out_win)
        ref_e_q <= '0;
      else if (ref_e_q.pend)
        ref_e_q.age <= ref_e_q.age + 3'h1;
      if (fb_p && !ref_p && !ref_e_q.pend)
        fb_e_q <= '{pend: 1'b1, age: 3'h0};
      else if (ref_p || out_win)
        fb_e_q <= '0;
      else if (fb_e_q.pend)
        fb_e_q.age <= fb_e_q.age + 3'h1;
    end
  end

  // Lock count: clear on a miss, step on a hit, hold at the threshold.
  always_comb
  begin
    lock_cnt_d = lock_cnt_q;
    if (out_win)
      lock_cnt_d = 16'h0000;
    else if (in_win && lock_cnt_q < cfg_q.lock_count_threshold)
      lock_cnt_d = lock_cnt_q + 16'h0001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lock_cnt_q <= 16'h0000;
      locked_q <= 1'b0;
    end
    else
    begin
      lock_cnt_q <= lock_cnt_d;
      locked_q <= !out_win &&
                  (lock_cnt_d >= cfg_q.lock_count_threshold);
    end
  end

  assign pll_locked = locked_q;
endmodule
`default_nettype wire

//--- tb/pdl_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Port checker for the loop divider block.
module pdl_top_checker #(
  parameter int NUM_CH = 4
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic ref_osc_input,
  input wire logic vco_clk,
  input wire logic ref_pd_clk,
  input wire logic fb_pd_clk,
  input wire logic [NUM_CH-1:0] ch_clk,
  input wire logic pll_locked
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // A read is taken when the slave is selected and the bus is ready.
  wire rd_take = hsel && hready && htrans[1] && !hwrite;
  // The slave answers at once, always OKAY, and read data stands.
  chk_ready_high: assert property (hreadyout)
    else $error("wait state inserted");
  chk_resp_okay: assert property (!hresp)
    else $error("error response");
  chk_unmapped_zero: assert property
    (rd_take && haddr[7:0] == 8'h14 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved");
  // Divided outputs move only when their source pin has moved or a bus transfer has run lately.
  chk_ref_quiet: assert property
    (($stable(ref_osc_input) && !htrans[1]) [*8] |=> $stable(ref_pd_clk))
    else $error("reference output moved");
  chk_fb_quiet: assert property
    (($stable(vco_clk) && !htrans[1]) [*8] |=> $stable(fb_pd_clk))
    else $error("feedback output moved");
  chk_ch_quiet: assert property
    (($stable(vco_clk) && !htrans[1]) [*8] |=> $stable(ch_clk))
    else $error("channel output moved");
  // Leaving reset, no divided output is high and no lock is claimed.
  chk_reset_clear: assert property
    ($rose(hresetn) |-> !pll_locked &&
     !ref_pd_clk && !fb_pd_clk && ch_clk == '0)
    else $error("outputs high after reset");
endmodule
bind pdl_top pdl_top_checker #(.NUM_CH(NUM_CH)) chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .ref_osc_input(ref_osc_input), .vco_clk(vco_clk),
  .ref_pd_clk(ref_pd_clk), .fb_pd_clk(fb_pd_clk), .ch_clk(ch_clk),
  .pll_locked(pll_locked)
);
`default_nettype wire

//--- tb/pdl_loop_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Oscillator and VCO of the analog loop, with a simple phase pull.
module pdl_loop_model #(
  parameter int OSC_HALF = 12,
  parameter int VCO_HALF = 3
)
(
  input wire logic hclk,
  input wire logic run,
  input wire logic pull,
  input wire logic kick,
  input wire logic ref_pd_clk,
  input wire logic fb_pd_clk,
  output logic ref_osc_input,
  output logic vco_clk
);
  int osc_n = 0;
  int vco_n = 0;
  int hold = 0;
  int fb_age = 0;
  logic ref_q = 1'b0;
  logic fb_q = 1'b0;
  logic osc_q = 1'b0;
  logic vco_q = 1'b0;
  // Both pins start low and follow their toggle flops.
  assign ref_osc_input = osc_q;
  assign vco_clk = vco_q;
  // The VCO is held back a cycle when a reference edge finds no feedback
  // edge just ahead of it; a kick throws the phase far off on purpose.
  always @(posedge hclk)
  begin
    fb_age = (fb_pd_clk && !fb_q) ? 0 : fb_age + 1;
    if (pull && ref_pd_clk && !ref_q && fb_age > 1)
      hold++;
    if (kick)
      hold += 2 * OSC_HALF - 2;
    ref_q = ref_pd_clk;
    fb_q = fb_pd_clk;
    if (run)
    begin
      osc_n = (osc_n + 1) % OSC_HALF;
      if (osc_n == 0)
        osc_q <= !osc_q;
      if (hold > 0)
        hold--;
      else if (++vco_n % VCO_HALF == 0)
        vco_q <= !vco_q;
    end
  end
endmodule
`default_nettype wire

//--- tb/pdl_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Self-checking bench for the loop divider block.
module pdl_top_bench;
  localparam int OSC_HALF = 12;
  localparam int VCO_HALF = 3;
  localparam logic [7:0] RA [7] = '{8'h0, 8'h4, 8'h8, 8'hc, 8'h10,
    8'h20, 8'h14};
  localparam logic [31:0] RV [7] = '{32'h20, 32'h1, 32'h1, 32'h400,
    32'h0, 32'h1, 32'h0};
  localparam logic [7:0] WA [8] = '{8'h4, 8'h4, 8'h8, 8'h8, 8'h0, 8'hc,
    8'h24, 8'h10};
  localparam logic [31:0] WD [8] = '{32'h0, 32'hfff, 32'h0, 32'h3ffff,
    32'hf1, 32'h1234, 32'h7ff, 32'hffffffff};
  localparam logic [31:0] WE [8] = '{32'h1, 32'hfff, 32'h1, 32'h3ffff,
    32'h81, 32'h1234, 32'h415, 32'h0};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic run = 1'b0;
  logic pull = 1'b0;
  logic kick = 1'b0;
  logic hreadyout, hresp, ref_osc_input, vco_clk;
  logic ref_pd_clk, fb_pd_clk, pll_locked;
  logic [31:0] hrdata;
  logic [3:0] ch_clk;
  int num_errors = 0;
  int checked = 0;
  int seed = 32'hf6e3f20d;
  pdl_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ref_osc_input(ref_osc_input), .vco_clk(vco_clk),
    .ref_pd_clk(ref_pd_clk), .fb_pd_clk(fb_pd_clk), .ch_clk(ch_clk),
    .pll_locked(pll_locked)
  );
  pdl_loop_model #(.OSC_HALF(OSC_HALF), .VCO_HALF(VCO_HALF)) loop (
    .hclk(hclk), .run(run), .pull(pull), .kick(kick),
    .ref_pd_clk(ref_pd_clk), .fb_pd_clk(fb_pd_clk),
    .ref_osc_input(ref_osc_input), .vco_clk(vco_clk)
  );
  // Clock with a 4 ns period.
  initial
    forever #2 hclk = ~hclk;
  function automatic logic sig(input int sel);
    case (sel)
      0: return ref_pd_clk;
      1: return fb_pd_clk;
      2: return pll_locked;
      3: return hreadyout;
      default: return ch_clk[sel-4];
    endcase
  endfunction
  // Expected period in clock cycles of a divided source.
  function automatic int span(input int a, input int b, input int c);
    return a * b / c;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      num_errors++;
      $display("unexpected at %0t: %h expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Waits for a level, counting edges; running out ends the run.
  task automatic wait_for(input int sel, input logic lvl, input int n,
                          output int t);
    t = 0;
    while (sig(sel) !== lvl)
    begin
      @(posedge hclk);
      t++;
      if (t > n)
      begin
        num_errors++;
        conclude();
      end
    end
  endtask
  // One settling period is skipped, then one whole period is counted.
  task automatic period(input int sel, output int p);
    int a;
    p = 0;
    for (int i = 0; i < 6; i++)
    begin
      wait_for(sel, i[0], 20000, a);
      if (i > 3)
        p += a;
    end
  endtask
  // Single AHB-Lite transfer of one word.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int t;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    wait_for(3, 1'b1, 50, t);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    wait_for(3, 1'b1, 50, t);
    rd = hrdata;
  endtask
  task automatic nudge();
    kick <= 1'b1;
    @(posedge hclk);
    kick <= 1'b0;
  endtask
  // Main sequence.
  initial
  begin
    logic [31:0] v, w;
    int p, r, d, pr, n, c, k, t;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (12) @(posedge hclk);
    foreach (RA[i])
    begin
      bus(1'b0, RA[i], 32'h0, v);
      check(v, RV[i]);
    end
    foreach (WA[i])
    begin
      bus(1'b1, WA[i], WD[i], v);
      bus(1'b0, WA[i], 32'h0, v);
      check(v, WE[i]);
    end
    run <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      d = i & 1;
      r = 2 + ($random(seed) & 7);
      pr = 2 + ({$random(seed)} % 7);
      n = 2 + ($random(seed) & 3);
      c = 1 + ($random(seed) & 15);
      k = $random(seed) & 3;
      bus(1'b1, 8'h0, pr * 16 + d, v);
      bus(1'b1, 8'h4, r, v);
      bus(1'b1, 8'h8, n, v);
      bus(1'b1, 8'(32 + 4 * k), c, v);
      period(0, p);
      check(p, span(2 * OSC_HALF, r, d + 1));
      period(1, p);
      check(p, span(2 * VCO_HALF * pr, n, 1));
      period(4 + k, p);
      check(p, span(2 * VCO_HALF, c, 1));
    end
    bus(1'b1, 8'h2c, 32'h415, v);
    period(7, p);
    check(p, span(2 * VCO_HALF, 1045, 1));
    bus(1'b1, 8'h0, 32'h21, v);
    bus(1'b1, 8'h4, 32'h2, v);
    bus(1'b1, 8'h8, 32'h2, v);
    pull <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      t = i == 0 ? 3 : 4 + ($random(seed) & 15);
      bus(1'b1, 8'hc, t, v);
      nudge();
      wait_for(2, 1'b0, 200, c);
      wait_for(2, 1'b1, 3000, c);
      check(c >= (t - 1) * 2 * OSC_HALF, 32'h1);
      bus(1'b0, 8'h10, 32'h0, v);
      check(v, t * 65536 + 1);
      repeat (240) @(posedge hclk);
      bus(1'b0, 8'h10, 32'h0, v);
      check(v, t * 65536 + 1);
    end
    bus(1'b1, 8'hc, 32'hffff, v);
    nudge();
    repeat (200) @(posedge hclk);
    bus(1'b0, 8'h10, 32'h0, w);
    repeat (22) @(posedge hclk);
    bus(1'b0, 8'h10, 32'h0, v);
    check(v >> 16, (w >> 16) + 32'h1);
    check(v & 32'h1, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
